// *** common/sbh_cfg.svh ***
`ifndef SBH_CFG_SVH
`define SBH_CFG_SVH

// Register offsets
`define SBH_OFS_DATA 8'hb0
`define SBH_OFS_INDEX 8'hb1
`define SBH_OFS_TARGET 8'hb2
`define SBH_OFS_CTRL 8'hb3

// Reset value of every software-visible register and field
`define SBH_RST_VAL 8'h00

// Control and status field positions
`define SBH_BIT_SKIP 7
`define SBH_BIT_RSVD 6
`define SBH_BIT_CBUSY 5
`define SBH_BIT_LBUSY 4
`define SBH_BIT_DET 3
`define SBH_BIT_FAST 2
`define SBH_BIT_CERR 1
`define SBH_BIT_LERR 0

// Target field layout
`define SBH_TGT_ADDR_MSB 7
`define SBH_TGT_ADDR_LSB 1
`define SBH_TGT_RW 0

// Timing
`define SBH_CLK_MHZ 250
`define SBH_NORM_PERIOD_NS 10000
`define SBH_FAST_PERIOD_NS 400
`define SBH_NORM_QTR ((`SBH_NORM_PERIOD_NS * `SBH_CLK_MHZ) / 4000)
`define SBH_FAST_QTR ((`SBH_FAST_PERIOD_NS * `SBH_CLK_MHZ) / 4000)

// Default load source and length
`define SBH_EEPROM_ADDR 7'h50
`define SBH_LOAD_BYTES 16

`endif

// *** common/sbh_pkg.sv ***
package sbh_pkg;

  typedef enum logic [1:0] {
    SBH_OP_START = 2'h0,
    SBH_OP_STOP = 2'h1,
    SBH_OP_WRITE = 2'h2,
    SBH_OP_READ = 2'h3
  } sbh_op_e;

  typedef struct packed {
    sbh_op_e op;
    logic [7:0] tx;
    logic ack;
  } sbh_cmd_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sbh_cfg_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] index;
    logic [7:0] data;
  } sbh_load_s;

endpackage

// *** logic/sbh_bit_engine.sv ***
`timescale 1ns/1ps
`include "sbh_cfg.svh"

module sbh_bit_engine (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic cmd_valid_i,
  input sbh_pkg::sbh_cmd_s cmd_i,
  input wire logic fast_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic done_o,
  output logic nack_o,
  output logic [7:0] rx_o,
  output logic scl_oe_o,
  output logic sda_oe_o
);
  import sbh_pkg::*;

  typedef enum logic [3:0] {
    E_IDLE = 4'h1,
    E_START = 4'h2,
    E_BIT = 4'h4,
    E_STOP = 4'h8
  } sbh_eng_e;

  localparam logic [9:0] NORM_RLD = 10'(`SBH_NORM_QTR - 1);
  localparam logic [9:0] FAST_RLD = 10'(`SBH_FAST_QTR - 1);

  sbh_eng_e state_q;
  logic [9:0] qcnt_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [8:0] tx_q;
  logic [8:0] rx_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic done_q;
  logic step;

  // Phase 2 waits while the target stretches the clock
  assign step = (qcnt_q == 10'h000) && !((phase_q == 2'h2) && !scl_i);

  // Quarter-bit timebase
  always_ff @(posedge ref_clk_i) begin
    if (srst_i || state_q == E_IDLE) begin
      qcnt_q <= fast_i ? FAST_RLD : NORM_RLD; // R12
    end else if (qcnt_q == 10'h000) begin
      qcnt_q <= step ? (fast_i ? FAST_RLD : NORM_RLD) : qcnt_q;
    end else begin
      qcnt_q <= qcnt_q - 10'h001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state_q <= E_IDLE;
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      tx_q <= 9'h1ff;
      rx_q <= 9'h000;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        E_IDLE: begin
          phase_q <= 2'h0;
          bit_q <= 4'h0;
          if (cmd_valid_i) begin
            case (cmd_i.op)
              SBH_OP_START: state_q <= E_START;
              SBH_OP_STOP: state_q <= E_STOP;
              default: state_q <= E_BIT;
            endcase
            tx_q <= (cmd_i.op == SBH_OP_READ) ? {8'hff, ~cmd_i.ack} : {cmd_i.tx, 1'b1};
          end
        end
        E_START: begin
          if (step) begin
            phase_q <= phase_q + 2'h1;
            case (phase_q)
              2'h0: sda_oe_q <= 1'b0;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b1; // R19
              default: begin
                scl_oe_q <= 1'b1;
                done_q <= 1'b1;
                state_q <= E_IDLE;
              end
            endcase
          end
        end
        E_BIT: begin
          if (step) begin
            phase_q <= phase_q + 2'h1;
            case (phase_q)
              2'h0: sda_oe_q <= ~tx_q[8];
              2'h1: scl_oe_q <= 1'b0;
              2'h2: rx_q <= {rx_q[7:0], sda_i};
              default: begin
                scl_oe_q <= 1'b1;
                tx_q <= {tx_q[7:0], 1'b1};
                bit_q <= bit_q + 4'h1;
                if (bit_q == 4'h8) begin
                  sda_oe_q <= 1'b0;
                  done_q <= 1'b1;
                  state_q <= E_IDLE;
                end
              end
            endcase
          end
        end
        E_STOP: begin
          if (step) begin
            phase_q <= phase_q + 2'h1;
            case (phase_q)
              2'h0: sda_oe_q <= 1'b1;
              2'h1: scl_oe_q <= 1'b0;
              2'h2: sda_oe_q <= 1'b0; // R19
              default: begin
                done_q <= 1'b1;
                state_q <= E_IDLE;
              end
            endcase
          end
        end
        default: state_q <= E_IDLE;
      endcase
    end
  end

  assign done_o = done_q;
  assign nack_o = rx_q[0];
  assign rx_o = rx_q[8:1];
  assign scl_oe_o = scl_oe_q;
  assign sda_oe_o = sda_oe_q;

endmodule // sbh_bit_engine

// *** logic/sbh_top.sv ***
`timescale 1ns/1ps
`include "sbh_cfg.svh"

// Function
// R1: Byte index register is the byte address sent to the target.
// R2: Software loads the byte index before writing the target register.
// R3: Writing the target register launches one serial cycle with that value.
// R4: Target register bits 7:1 give the target device address.
// R5: Target register bit 0: zero is byte write, one is byte read.
// R6: Skip bit zero sends address and index; one sends address only.
// R7: Cycle busy flag is high exactly while a software cycle runs.
// R8: Load busy flag is high while defaults download from the EEPROM.
// R9: Detected flag set on finding an EEPROM, once per link or global reset.
// R10: Detected flag enables the serial interface and gates the default load.
// R11: Software may set detected flag; no load then follows.
// R12: Fast test bit selects test clock rate instead of about 100 kHz.
// R13: Cycle error flag set on failed software cycle, cleared by reading.
// R14: Load error flag set on download failure, cleared by reading.
// R15: All registers return to zero on link, global or power-on reset.
// R16: Control bit 6 is reserved and reads zero.
// R17: Software writes the data byte before launching a write cycle.
// R18: Read cycle leaves received byte in data register once busy clears.
// R19: Cycles use start, address, acknowledge and stop; missing ack is an error.
module sbh_top #(
  parameter logic [6:0] EEPROM_ADDR = `SBH_EEPROM_ADDR,
  parameter int LOAD_BYTES = `SBH_LOAD_BYTES
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic link_reset_n_i,
  input wire logic global_reset_n_i,
  input sbh_pkg::sbh_cfg_req_s cfg_req_i,
  output logic [7:0] cfg_rdata_o,
  output sbh_pkg::sbh_load_s load_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  import sbh_pkg::*;

  typedef enum logic [7:0] {
    T_IDLE = 8'h01,
    T_START = 8'h02,
    T_ADDR = 8'h04,
    T_INDEX = 8'h08,
    T_RSTART = 8'h10,
    T_ADDRR = 8'h20,
    T_DATA = 8'h40,
    T_STOP = 8'h80
  } sbh_seq_e;

  localparam logic [7:0] LAST_IDX = 8'(LOAD_BYTES - 1);

  function automatic logic reg_hit(input logic strobe, input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = strobe && (addr == ofs);
  endfunction

  // Pin synchronisers: scl, sda, link reset, global reset
  logic [3:0] pin_raw;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic scl_s;
  logic sda_s;
  logic rst;

  assign pin_raw = {global_reset_n_i, link_reset_n_i, sda_i, scl_i};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
          pin_s1_q[gi] <= 1'b1;
          pin_s2_q[gi] <= 1'b1;
        end else begin
          pin_s1_q[gi] <= pin_raw[gi];
          pin_s2_q[gi] <= pin_s1_q[gi];
        end
      end
    end
  endgenerate

  assign scl_s = pin_s2_q[0];
  assign sda_s = pin_s2_q[1];
  assign rst = srst_i || !pin_s2_q[2] || !pin_s2_q[3]; // R15

  // Register file
  logic [7:0] data_q;
  logic [7:0] index_q;
  logic [7:0] target_q;
  logic skip_q;
  logic det_q;
  logic fast_q;
  logic cerr_q;
  logic lerr_q;
  logic [7:0] rdata_q;

  // Sequencer state
  sbh_seq_e state_q;
  sbh_seq_e state_d;
  logic owner_load_q;
  logic load_pend_q;
  logic [7:0] load_idx_q;
  logic fail_q;
  logic [6:0] cur_addr_q;
  logic cur_rd_q;
  logic cur_skip_q;
  logic [7:0] cur_idx_q;
  logic [7:0] cur_wdata_q;
  logic [7:0] rx_hold_q;
  sbh_load_s load_q;

  // Engine link
  sbh_cmd_s cmd_q;
  sbh_cmd_s cmd_d;
  logic cmd_valid_q;
  logic issue_d;
  logic eng_done;
  logic eng_nack;
  logic [7:0] eng_rx;

  logic wr_data;
  logic wr_index;
  logic wr_target;
  logic wr_ctrl;
  logic rd_ctrl;
  logic launch;
  logic load_go;
  logic cycle_busy;
  logic load_busy;
  logic ack_miss;
  logic sw_fail_evt;
  logic load_fail_evt;
  logic seq_end;
  logic [7:0] ctrl_view;

  assign wr_data = reg_hit(cfg_req_i.wr, cfg_req_i.addr, `SBH_OFS_DATA);
  assign wr_index = reg_hit(cfg_req_i.wr, cfg_req_i.addr, `SBH_OFS_INDEX);
  assign wr_target = reg_hit(cfg_req_i.wr, cfg_req_i.addr, `SBH_OFS_TARGET);
  assign wr_ctrl = reg_hit(cfg_req_i.wr, cfg_req_i.addr, `SBH_OFS_CTRL);
  assign rd_ctrl = reg_hit(cfg_req_i.rd, cfg_req_i.addr, `SBH_OFS_CTRL);

  // Load has priority; software cycles need the interface enabled
  assign load_go = (state_q == T_IDLE) && load_pend_q;
  assign launch = wr_target && (state_q == T_IDLE) && !load_pend_q && det_q; // R3 R10

  assign cycle_busy = (state_q != T_IDLE) && !owner_load_q; // R7
  assign load_busy = owner_load_q && det_q && ((state_q != T_IDLE) || load_pend_q); // R8

  // Ack missing on an address, index or written data byte
  assign ack_miss = eng_done && eng_nack &&
                    ((state_q == T_ADDR) || (state_q == T_INDEX) || (state_q == T_ADDRR) ||
                     ((state_q == T_DATA) && !cur_rd_q)); // R19
  assign seq_end = eng_done && (state_q == T_STOP);
  assign sw_fail_evt = seq_end && !owner_load_q && fail_q; // R13
  assign load_fail_evt = seq_end && owner_load_q && fail_q && det_q; // R14

  // Next step and the engine command that opens it
  always_comb begin
    state_d = state_q;
    issue_d = 1'b0;
    cmd_d = '{op: SBH_OP_START, tx: 8'h00, ack: 1'b0};
    case (state_q)
      T_IDLE: begin
        if (load_go || launch) begin
          state_d = T_START;
          issue_d = 1'b1;
        end
      end
      T_START: begin
        if (eng_done) begin
          state_d = T_ADDR;
          issue_d = 1'b1;
          cmd_d = '{op: SBH_OP_WRITE, tx: {cur_addr_q, cur_rd_q && cur_skip_q}, ack: 1'b0}; // R4 R6
        end
      end
      T_ADDR: begin
        if (eng_done) begin
          issue_d = 1'b1;
          if (ack_miss) begin
            state_d = T_STOP;
            cmd_d.op = SBH_OP_STOP;
          end else if (cur_skip_q) begin
            state_d = T_DATA; // R6
            cmd_d = '{op: cur_rd_q ? SBH_OP_READ : SBH_OP_WRITE, tx: cur_wdata_q, ack: 1'b0};
          end else begin
            state_d = T_INDEX;
            cmd_d = '{op: SBH_OP_WRITE, tx: cur_idx_q, ack: 1'b0}; // R1
          end
        end
      end
      T_INDEX: begin
        if (eng_done) begin
          issue_d = 1'b1;
          if (ack_miss) begin
            state_d = T_STOP;
            cmd_d.op = SBH_OP_STOP;
          end else if (cur_rd_q) begin
            state_d = T_RSTART;
          end else begin
            state_d = T_DATA;
            cmd_d = '{op: SBH_OP_WRITE, tx: cur_wdata_q, ack: 1'b0}; // R17
          end
        end
      end
      T_RSTART: begin
        if (eng_done) begin
          state_d = T_ADDRR;
          issue_d = 1'b1;
          cmd_d = '{op: SBH_OP_WRITE, tx: {cur_addr_q, 1'b1}, ack: 1'b0}; // R5
        end
      end
      T_ADDRR: begin
        if (eng_done) begin
          issue_d = 1'b1;
          if (ack_miss) begin
            state_d = T_STOP;
            cmd_d.op = SBH_OP_STOP;
          end else begin
            state_d = T_DATA;
            cmd_d = '{op: SBH_OP_READ, tx: 8'hff, ack: 1'b0};
          end
        end
      end
      T_DATA: begin
        if (eng_done) begin
          state_d = T_STOP;
          issue_d = 1'b1;
          cmd_d.op = SBH_OP_STOP;
        end
      end
      T_STOP: begin
        if (eng_done) begin
          state_d = T_IDLE;
        end
      end
      default: state_d = T_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      state_q <= T_IDLE;
      cmd_valid_q <= 1'b0;
      cmd_q <= '{op: SBH_OP_START, tx: 8'h00, ack: 1'b0};
    end else begin
      state_q <= state_d;
      cmd_valid_q <= issue_d;
      cmd_q <= cmd_d;
    end
  end

  // Cycle parameters latched at launch
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      owner_load_q <= 1'b0;
      cur_addr_q <= 7'h00;
      cur_rd_q <= 1'b0;
      cur_skip_q <= 1'b0;
      cur_idx_q <= `SBH_RST_VAL;
      cur_wdata_q <= `SBH_RST_VAL;
    end else if (load_go) begin
      owner_load_q <= 1'b1;
      cur_addr_q <= EEPROM_ADDR;
      cur_rd_q <= 1'b1;
      cur_skip_q <= 1'b0;
      cur_idx_q <= load_idx_q;
    end else if (launch) begin
      owner_load_q <= 1'b0;
      cur_addr_q <= cfg_req_i.wdata[`SBH_TGT_ADDR_MSB:`SBH_TGT_ADDR_LSB]; // R3 R4
      cur_rd_q <= cfg_req_i.wdata[`SBH_TGT_RW]; // R5
      cur_skip_q <= skip_q; // R6
      cur_idx_q <= index_q; // R1
      cur_wdata_q <= data_q;
    end
  end

  // Failure seen within the current cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst || (state_q == T_IDLE)) begin
      fail_q <= 1'b0;
    end else if (ack_miss) begin
      fail_q <= 1'b1; // R19
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      rx_hold_q <= `SBH_RST_VAL;
    end else if (eng_done && (state_q == T_DATA) && cur_rd_q) begin
      rx_hold_q <= eng_rx;
    end
  end

  // Detection and default load, once per reset
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      load_pend_q <= 1'b1; // R9
      load_idx_q <= 8'h00;
      load_q <= '{valid: 1'b0, index: 8'h00, data: 8'h00};
    end else begin
      load_q.valid <= 1'b0;
      if (load_go) begin
        load_pend_q <= 1'b0;
      end else if (seq_end && owner_load_q && !fail_q && det_q) begin // R10
        load_q <= '{valid: 1'b1, index: cur_idx_q, data: rx_hold_q};
        if (load_idx_q != LAST_IDX) begin
          load_idx_q <= load_idx_q + 8'h01;
          load_pend_q <= 1'b1;
        end
      end
    end
  end

  // Software-visible registers
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      data_q <= `SBH_RST_VAL; // R15
      index_q <= `SBH_RST_VAL;
      target_q <= `SBH_RST_VAL;
    end else begin
      if (wr_index) begin
        index_q <= cfg_req_i.wdata; // R2
      end
      if (wr_target) begin
        target_q <= cfg_req_i.wdata;
      end
      if (seq_end && !owner_load_q && cur_rd_q && !fail_q) begin
        data_q <= rx_hold_q; // R18
      end else if (wr_data) begin
        data_q <= cfg_req_i.wdata; // R17
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      skip_q <= 1'b0;
      fast_q <= 1'b0;
    end else if (wr_ctrl) begin
      skip_q <= cfg_req_i.wdata[`SBH_BIT_SKIP]; // R6
      fast_q <= cfg_req_i.wdata[`SBH_BIT_FAST]; // R12
    end
  end

  // Detected on the first address ack of the load; software may also set it
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      det_q <= 1'b0;
    end else if (eng_done && (state_q == T_ADDR) && owner_load_q && !eng_nack && !det_q) begin
      det_q <= 1'b1; // R9
    end else if (wr_ctrl) begin
      det_q <= cfg_req_i.wdata[`SBH_BIT_DET]; // R11
    end
  end

  // Error flags: a new error wins over the clearing read
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      cerr_q <= 1'b0;
      lerr_q <= 1'b0;
    end else begin
      if (sw_fail_evt) begin
        cerr_q <= 1'b1; // R13
      end else if (rd_ctrl) begin
        cerr_q <= 1'b0; // R13
      end
      if (load_fail_evt) begin
        lerr_q <= 1'b1; // R14
      end else if (rd_ctrl) begin
        lerr_q <= 1'b0; // R14
      end
    end
  end

  always_comb begin
    ctrl_view = `SBH_RST_VAL;
    ctrl_view[`SBH_BIT_SKIP] = skip_q;
    ctrl_view[`SBH_BIT_RSVD] = 1'b0; // R16
    ctrl_view[`SBH_BIT_CBUSY] = cycle_busy; // R7
    ctrl_view[`SBH_BIT_LBUSY] = load_busy; // R8
    ctrl_view[`SBH_BIT_DET] = det_q;
    ctrl_view[`SBH_BIT_FAST] = fast_q;
    ctrl_view[`SBH_BIT_CERR] = cerr_q;
    ctrl_view[`SBH_BIT_LERR] = lerr_q;
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      rdata_q <= `SBH_RST_VAL;
    end else if (cfg_req_i.rd) begin
      case (cfg_req_i.addr)
        `SBH_OFS_DATA: rdata_q <= data_q;
        `SBH_OFS_INDEX: rdata_q <= index_q;
        `SBH_OFS_TARGET: rdata_q <= target_q;
        `SBH_OFS_CTRL: rdata_q <= ctrl_view;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  sbh_bit_engine u_engine (
    .ref_clk_i(ref_clk_i),
    .srst_i(rst),
    .cmd_valid_i(cmd_valid_q),
    .cmd_i(cmd_q),
    .fast_i(fast_q),
    .scl_i(scl_s),
    .sda_i(sda_s),
    .done_o(eng_done),
    .nack_o(eng_nack),
    .rx_o(eng_rx),
    .scl_oe_o(scl_oe_o),
    .sda_oe_o(sda_oe_o)
  );

  assign cfg_rdata_o = rdata_q;
  assign load_o = load_q;
  // Open drain: the pins only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

endmodule // sbh_top

// *** tb/sbh_top_props.sv ***
`timescale 1ns/1ps
`include "sbh_cfg.svh"

module sbh_top_props #(
  parameter int LOAD_BYTES = 16
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic link_reset_n_i,
  input wire logic global_reset_n_i,
  input sbh_pkg::sbh_cfg_req_s cfg_req_i,
  input wire logic [7:0] cfg_rdata_o,
  input sbh_pkg::sbh_load_s load_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o
);
  import sbh_pkg::*;
  localparam int QMIN = 24;
  logic [15:0] qcnt_q;
  logic [15:0] idle_q;
  logic any_rst;
  assign any_rst = srst_i || !link_reset_n_i || !global_reset_n_i;
  // Cycles since the clock line last moved
  always_ff @(posedge ref_clk_i) begin
    if (any_rst) qcnt_q <= 16'h0018;
    else if ($changed(scl_oe_o)) qcnt_q <= 16'h0000;
    else if (qcnt_q != 16'hffff) qcnt_q <= qcnt_q + 16'h0001;
  end
  // Cycles with neither line pulled since the last pull or launch
  always_ff @(posedge ref_clk_i) begin
    if (any_rst || scl_oe_o || sda_oe_o) idle_q <= 16'h0000;
    else if (cfg_req_i.wr && cfg_req_i.addr == `SBH_OFS_TARGET) idle_q <= 16'h0000;
    else if (idle_q != 16'hffff) idle_q <= idle_q + 16'h0001;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (any_rst);
  sequence s_rd_ctrl;
    cfg_req_i.rd && cfg_req_i.addr == `SBH_OFS_CTRL;
  endsequence
  sequence s_ctrl_idle;
    s_rd_ctrl ##1 (!cfg_rdata_o[5] && !cfg_rdata_o[4] && !cfg_req_i.wr) ##1 !cfg_req_i.wr ##1 s_rd_ctrl;
  endsequence
  property p_rst_clear;
    disable iff (1'b0) srst_i |=> cfg_rdata_o == 8'h00 && load_o == '0 && !scl_oe_o && !sda_oe_o;
  endproperty
  property p_open_drain;
    scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  property p_rsvd_zero;
    s_rd_ctrl |=> cfg_rdata_o[`SBH_BIT_RSVD] == 1'b0;
  endproperty
  property p_err_clear;
    s_ctrl_idle |=> cfg_rdata_o[1:0] == 2'b00;
  endproperty
  property p_qtr_min;
    $changed(scl_oe_o) |-> qcnt_q >= QMIN;
  endproperty
  property p_busy_active;
    s_rd_ctrl ##1 cfg_rdata_o[`SBH_BIT_CBUSY] |-> idle_q < 16'd2000;
  endproperty
  property p_load_pulse;
    load_o.valid |=> !load_o.valid;
  endproperty
  property p_start_form;
    $rose(sda_oe_o) && !scl_oe_o |-> !scl_oe_o [*8];
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not cleared by reset");
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit reads one");
  a_err_clear: assert property (p_err_clear) else $error("error flags survive a read");
  a_qtr_min: assert property (p_qtr_min) else $error("clock phase shorter than a quarter");
  a_busy_active: assert property (p_busy_active) else $error("busy with no bus activity");
  a_load_pulse: assert property (p_load_pulse) else $error("load strobe longer than a cycle");
  a_start_form: assert property (p_start_form) else $error("start without clock high");
endmodule // sbh_top_props

bind sbh_top sbh_top_props #(.LOAD_BYTES(LOAD_BYTES)) u_props (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .link_reset_n_i(link_reset_n_i),
  .global_reset_n_i(global_reset_n_i), .cfg_req_i(cfg_req_i), .cfg_rdata_o(cfg_rdata_o),
  .load_o(load_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o)
);

// *** tb/sbh_eeprom_model.sv ***
`timescale 1ns/1ps

module sbh_eeprom_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic stretch_i,
  output logic scl_pull_o,
  output logic sda_pull_o,
  output logic [7:0] stops_o,
  output logic [7:0] nbyte_o,
  output logic [7:0] abyte_o
);
  logic [7:0] mem [256];
  logic [7:0] sh, ptr, tx;
  int bitc, st;
  // st: 0 idle, 1 address, 2 index, 3 data in, 4 data out, 5 wait for stop
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = ~i[7:0];
    {scl_pull_o, sda_pull_o, stops_o, nbyte_o, abyte_o, sh, ptr, tx} = '0;
    bitc = 0;
    st = 0;
  end
  always @(negedge sda_i) if (scl_i === 1'b1) begin
    st = 1;
    bitc = 0;
    nbyte_o = 8'h00;
  end
  always @(posedge sda_i) if (scl_i === 1'b1 && st != 0) begin
    st = 0;
    stops_o = stops_o + 8'h01;
  end
  always @(posedge scl_i) begin
    if (st >= 1 && st <= 3 && bitc < 8) sh = {sh[6:0], sda_i};
    bitc = bitc + 1;
  end
  always @(negedge scl_i) begin
    if (stretch_i) scl_pull_o = 1'b1;
    if (st == 4) begin
      if (bitc < 8) sda_pull_o = ~tx[7 - bitc];
      else sda_pull_o = 1'b0;
      if (bitc >= 9) st = 5;
    end else if (st >= 1 && st <= 3 && bitc == 8) begin
      if (st == 1) abyte_o = sh;
      sda_pull_o = (st != 1) || (sh[7:1] == ADDR);
      if (!sda_pull_o) st = 5;
      else nbyte_o = nbyte_o + 8'h01;
    end else if (st >= 1 && st <= 3 && bitc == 9) begin
      sda_pull_o = 1'b0;
      bitc = 0;
      if (st == 1 && sh[0]) begin
        st = 4;
        tx = mem[ptr];
        ptr = ptr + 8'h01;
        sda_pull_o = ~tx[7];
      end else if (st == 1) st = 2;
      else if (st == 2) begin
        ptr = sh;
        st = 3;
      end else begin
        mem[ptr] = sh;
        ptr = ptr + 8'h01;
      end
    end
    if (stretch_i) begin
      #300;
      scl_pull_o = 1'b0;
    end
  end
endmodule // sbh_eeprom_model

// *** tb/tb_sbh_top.sv ***
`timescale 1ns/1ps
`include "sbh_cfg.svh"

module tb_sbh_top;
  import sbh_pkg::*;
  localparam logic [6:0] TGT = 7'h2a;
  logic ref_clk, srst, link_rst_n, glob_rst_n, stretch;
  logic scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull, scl_w, sda_w;
  logic [7:0] rdata, stops, nbyte, abyte, v;
  sbh_cfg_req_s req;
  sbh_load_s load;
  int failures = 0;
  int n_checks = 0;
  int n_load = 0;
  assign scl_w = ~(scl_oe | scl_pull);
  assign sda_w = ~(sda_oe | sda_pull);
  sbh_top #(.LOAD_BYTES(2)) uut (
    .ref_clk_i(ref_clk), .srst_i(srst), .link_reset_n_i(link_rst_n), .global_reset_n_i(glob_rst_n),
    .cfg_req_i(req), .cfg_rdata_o(rdata), .load_o(load), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe)
  );
  sbh_eeprom_model #(.ADDR(TGT)) u_model (
    .scl_i(scl_w), .sda_i(sda_w), .stretch_i(stretch), .scl_pull_o(scl_pull),
    .sda_pull_o(sda_pull), .stops_o(stops), .nbyte_o(nbyte), .abyte_o(abyte)
  );
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (load.valid === 1'b1) n_load++;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge ref_clk);
    req.rd = 1'b0;
    @(negedge ref_clk);
    d = rdata;
  endtask
  task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    check(d, e);
  endtask
  task automatic wait_idle(output logic [7:0] d);
    rd(`SBH_OFS_CTRL, d);
    check({7'h00, d[5]}, 8'h01);
    for (int i = 0; i < 4000 && d[5] !== 1'b0; i++) rd(`SBH_OFS_CTRL, d);
    check({7'h00, d[5]}, 8'h00);
  endtask
  task automatic t_reset_values();
    for (int i = 0; i < 5; i++) expect_rd(`SBH_OFS_DATA + i[7:0], 8'h00);
    $display("test reset_values done");
  endtask
  task automatic t_detect();
    for (int i = 0; i < 40000 && stops !== 8'h01; i++) @(negedge ref_clk);
    check(abyte, {`SBH_EEPROM_ADDR, 1'b0});
    expect_rd(`SBH_OFS_CTRL, 8'h00);
    wr(`SBH_OFS_INDEX, 8'h01);
    wr(`SBH_OFS_TARGET, {TGT, 1'b0});
    repeat (1000) @(negedge ref_clk);
    check(stops, 8'h01);
    expect_rd(`SBH_OFS_CTRL, 8'h00);
    $display("test detect done");
  endtask
  task automatic t_enable();
    wr(`SBH_OFS_CTRL, 8'h7f);
    expect_rd(`SBH_OFS_CTRL, 8'h0c);
    $display("test enable done");
  endtask
  task automatic t_write_read();
    wr(`SBH_OFS_DATA, 8'h5a);
    wr(`SBH_OFS_INDEX, 8'h10);
    wr(`SBH_OFS_TARGET, {TGT, 1'b0});
    wait_idle(v);
    check(u_model.mem[8'h10], 8'h5a);
    check(nbyte, 8'h03);
    stretch = 1'b1;
    wr(`SBH_OFS_DATA, 8'h00);
    wr(`SBH_OFS_INDEX, 8'h10);
    wr(`SBH_OFS_TARGET, {TGT, 1'b1});
    wait_idle(v);
    stretch = 1'b0;
    expect_rd(`SBH_OFS_DATA, 8'h5a);
    check(n_load[7:0], 8'h00);
    $display("test write_read done");
  endtask
  task automatic t_skip();
    wr(`SBH_OFS_CTRL, 8'h8c);
    wr(`SBH_OFS_DATA, 8'hc3);
    wr(`SBH_OFS_TARGET, {TGT, 1'b0});
    wait_idle(v);
    check(nbyte, 8'h02);
    wr(`SBH_OFS_TARGET, {TGT, 1'b1});
    wait_idle(v);
    expect_rd(`SBH_OFS_DATA, 8'h3c);
    $display("test skip done");
  endtask
  task automatic t_nack();
    wr(`SBH_OFS_TARGET, {TGT ^ 7'h01, 1'b0});
    wait_idle(v);
    check(v, 8'h8e);
    expect_rd(`SBH_OFS_CTRL, 8'h8c);
    $display("test nack done");
  endtask
  task automatic t_pin_reset();
    for (int p = 0; p < 2; p++) begin
      wr(`SBH_OFS_DATA, 8'h77);
      wr(`SBH_OFS_INDEX, 8'h66);
      @(negedge ref_clk);
      if (p == 0) link_rst_n = 1'b0;
      else glob_rst_n = 1'b0;
      repeat (8) @(negedge ref_clk);
      link_rst_n = 1'b1;
      glob_rst_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      expect_rd(`SBH_OFS_DATA, 8'h00);
      expect_rd(`SBH_OFS_INDEX, 8'h00);
      expect_rd(`SBH_OFS_CTRL, 8'h00);
    end
    $display("test pin_reset done");
  endtask
  initial begin
    srst = 1'b1;
    link_rst_n = 1'b1;
    glob_rst_n = 1'b1;
    stretch = 1'b0;
    req = '0;
    repeat (12) @(negedge ref_clk);
    srst = 1'b0;
    t_reset_values();
    t_detect();
    t_enable();
    t_write_read();
    t_skip();
    t_nack();
    t_pin_reset();
    complete_run();
  end
  initial begin
    repeat (80000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
endmodule // tb_sbh_top
